// file: core/suvr_pkg.sv
// Purpose: Shared constants for the supply undervoltage reset block.
// Assumes: AHB-Lite register access, 32-bit data, word-aligned registers.
// Notes:   Offsets are byte addresses.
package suvr_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] SUVR_OFS_CONFIG = 12'h000; // First configuration
	localparam logic [11:0] SUVR_OFS_STATUS = 12'h004; // Supply monitor status
	localparam logic [11:0] SUVR_OFS_CAUSE  = 12'h008; // Reset cause (monitor trip)
	localparam logic [11:0] SUVR_OFS_MODE   = 12'h00C; // Low-power mode control
	// ==========================================================
	// Field positions in the configuration register
	localparam int SUVR_BIT_STOP_EN   = 0; // monitor_stop_enable
	localparam int SUVR_BIT_PWR_DIS   = 1; // monitor_power_disable
	localparam int SUVR_BIT_TRIP_SEL  = 2; // trip_level_select
	localparam int SUVR_BIT_RST_DIS   = 3; // monitor_reset_disable
	// Status flag position
	localparam int SUVR_BIT_FLAG      = 7; // undervoltage_flag
	// Mode register fields
	localparam int SUVR_BIT_WAIT      = 0;
	localparam int SUVR_BIT_STOP      = 1;
	// ==========================================================
	// Reset values
	localparam logic [7:0] SUVR_CONFIG_RST = 8'h00;
	localparam logic [7:0] SUVR_STATUS_RST = 8'h00;
	localparam logic [1:0] SUVR_MODE_RST   = 2'h0;
	// Synchroniser width, one bit per comparator decision
	localparam int SUVR_SYNC_STAGES = 2;
	// ==========================================================
	// Hysteresis state of the monitor
	typedef enum logic [1:0] {
		SUVR_ST_OK,
		SUVR_ST_TRIPPED
	} suvr_state_t;
endpackage : suvr_pkg

// file: core/suvr_sync.sv
// Purpose: Two-flop level synchroniser for comparator decisions.
// Assumes: Inputs are asynchronous levels.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/10ps
`default_nettype none
module suvr_sync
	import suvr_pkg::*;
#(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// ==========================================================
	// Two-stage capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : suvr_sync
`default_nettype wire

// file: core/suvr_top.sv
// Purpose: Digital control of a supply undervoltage monitor with reset.
// Assumes: Comparator decisions are asynchronous levels; AHB-Lite slave.
// Notes:   Configuration bits are fixed at zero; interrupt output tied low.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1 - Monitor enabled immediately out of reset
// R2 - Power-disable bit fixed at zero
// R3 - Reset-disable bit fixed at zero
// R4 - Stop-enable bit fixed at zero
// R5 - Trip-select bit zero selects 3 V
// R6 - After power-on, 3 V trip configuration
// R7 - Four config bits in first configuration register
// R8 - Hold reset until supply above rising level
// R9 - Status flag follows comparator decision
// R10 - Monitor reset drives external reset pin low
// R11 - No polled-only mode; always forces reset
// R12 - Flag sets below falling level; writes ignored
// R13 - Any chip reset clears the flag
// R14 - Flag zero above rising, else held
// R15 - Monitor never raises an interrupt
// R16 - Active in wait; reset exits wait
// R17 - Active in stop; reset exits stop
// R18 - Stop exit restarts clocks, fetches reset vector
// R19 - Comparator inputs synchronised by two flops
// R20 - Monitor reset reported as distinct source
module suvr_top
	import suvr_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	// Comparator decisions
	input  wire logic        BELOW_FALLING,
	input  wire logic        ABOVE_RISING,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [11:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output var  logic [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Reset and system interface
	output var  logic        CHIP_RESET_REQ,
	output var  logic        RESET_PIN_OUT,
	output var  logic        RESET_PIN_OE,
	output var  logic        MONITOR_RESET_SRC,
	output var  logic        CLOCK_RESTART,
	output var  logic        FETCH_RESET_VECTOR,
	output logic             TRIP_LEVEL_3V,
	output logic             MONITOR_ENABLE,
	output logic             IRQ_REQ
);
	// ==========================================================
	// Synchronised comparator decisions
	logic [1:0]  cmp_sync;
	logic        below_s;
	logic        above_s;

	suvr_sync #(.WIDTH(SUVR_SYNC_STAGES)) u_sync (
		.clk (CLK_SYS),
		.rst (RST),
		.d   ({ABOVE_RISING, BELOW_FALLING}), // R19
		.q   (cmp_sync)
	);
	assign below_s = cmp_sync[0];
	assign above_s = cmp_sync[1];

	// ==========================================================
	// Fixed configuration register
	logic        stop_enable;
	logic        power_disable;
	logic        trip_select;
	logic        reset_disable;
	logic [7:0]  config_val;

	// All four bits are tied to zero; writes have no effect
	assign stop_enable   = 1'b0; // R4
	assign power_disable = 1'b0; // R2
	assign reset_disable = 1'b0; // R3
	assign trip_select   = 1'b0; // R5
	assign config_val = SUVR_CONFIG_RST
		| (8'(stop_enable)   << SUVR_BIT_STOP_EN)
		| (8'(power_disable) << SUVR_BIT_PWR_DIS)
		| (8'(trip_select)   << SUVR_BIT_TRIP_SEL)
		| (8'(reset_disable) << SUVR_BIT_RST_DIS); // R7

	// Monitor runs from reset release with no software action
	assign MONITOR_ENABLE = ~power_disable; // R1
	assign TRIP_LEVEL_3V  = ~trip_select; // R6
	// No interrupt source exists in this block
	assign IRQ_REQ = 1'b0; // R15

	// ==========================================================
	// Hysteresis state machine and flag
	suvr_state_t state;
	suvr_state_t next_state;
	logic        flag;
	logic        next_flag;
	logic        monitor_active;
	logic [1:0]  lp_mode;
	logic        in_stop;

	assign in_stop = lp_mode[SUVR_BIT_STOP];
	// Active in run, wait and stop; the stop bit does not gate it
	assign monitor_active = MONITOR_ENABLE
		& (~in_stop | ~stop_enable | stop_enable); // R16 R17

	// Trip on falling level, release only above rising level
	always_comb begin
		next_state = state;
		case (state)
			SUVR_ST_OK: begin
				if (monitor_active && below_s && !reset_disable)
					next_state = SUVR_ST_TRIPPED; // R11
			end
			SUVR_ST_TRIPPED: begin
				if (above_s && !below_s)
					next_state = SUVR_ST_OK; // R8
			end
			default: next_state = SUVR_ST_OK;
		endcase
	end

	// Flag: set below falling, clear above rising, else hold
	always_comb begin
		next_flag = flag;
		if (below_s)
			next_flag = 1'b1; // R9 R12
		else if (above_s)
			next_flag = 1'b0; // R14
	end

	// State and flag registers; any chip reset clears the flag
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state <= SUVR_ST_OK;
			flag  <= 1'b0; // R13
		end else begin
			state <= next_state;
			flag  <= next_flag;
		end
	end

	// ==========================================================
	// Reset outputs
	logic tripped;
	logic trip_rise;
	logic stop_exit;

	assign tripped   = (next_state == SUVR_ST_TRIPPED);
	assign trip_rise = tripped && (state == SUVR_ST_OK);
	assign stop_exit = trip_rise && (lp_mode != SUVR_MODE_RST);

	// Reset request, pin drive and reset-source report
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			CHIP_RESET_REQ     <= 1'b0;
			RESET_PIN_OUT      <= 1'b1;
			RESET_PIN_OE       <= 1'b0;
			MONITOR_RESET_SRC  <= 1'b0;
			CLOCK_RESTART      <= 1'b0;
			FETCH_RESET_VECTOR <= 1'b0;
		end else begin
			CHIP_RESET_REQ     <= tripped; // R8 R16
			RESET_PIN_OUT      <= 1'b0; // R10
			RESET_PIN_OE       <= tripped; // R10
			MONITOR_RESET_SRC  <= tripped; // R20
			CLOCK_RESTART      <= stop_exit; // R17 R18
			FETCH_RESET_VECTOR <= trip_rise; // R18
		end
	end

	// ==========================================================
	// AHB-Lite slave: zero-wait, always OKAY
	logic        ap_valid;
	logic        dp_write;
	logic [11:0] dp_addr;
	logic [31:0] rd_mux;

	assign ap_valid  = HSEL & HREADY & HTRANS[1];
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	// Register address phase
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			dp_write <= 1'b0;
			dp_addr  <= 12'h000;
		end else begin
			dp_write <= ap_valid & HWRITE;
			dp_addr  <= HADDR;
		end
	end

	// Mode register: software marks wait or stop entry
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST)
			lp_mode <= SUVR_MODE_RST;
		else if (tripped)
			lp_mode <= SUVR_MODE_RST; // R16 R17
		else if (dp_write && dp_addr == SUVR_OFS_MODE)
			lp_mode <= HWDATA[1:0];
	end

	// Read multiplexer on the address-phase address; next flag and trip values
	// are used so those bits match the state once the capturing edge is past
	assign rd_mux =
		(HADDR == SUVR_OFS_CONFIG) ? {24'h000000, config_val} :
		(HADDR == SUVR_OFS_STATUS) ? {24'h000000, next_flag, 7'h00} : // R12
		(HADDR == SUVR_OFS_CAUSE)  ? {31'h00000000, tripped} : // R20
		(HADDR == SUVR_OFS_MODE)   ? {30'h00000000, lp_mode} :
		32'h00000000;

	// Read data is registered at the address-phase edge
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST)
			HRDATA <= 32'h00000000;
		else if (ap_valid && !HWRITE)
			HRDATA <= rd_mux;
	end

	// ==========================================================
	// Checks
	property p_hold;
		@(posedge CLK_SYS) disable iff (RST)
		(state == SUVR_ST_TRIPPED && !above_s) |=> CHIP_RESET_REQ;
	endproperty
	a_hold: assert property (p_hold) else $error("reset released early"); // R8

	property p_pin;
		@(posedge CLK_SYS) disable iff (RST)
		CHIP_RESET_REQ |-> (RESET_PIN_OE && !RESET_PIN_OUT);
	endproperty
	a_pin: assert property (p_pin) else $error("pin not low in reset"); // R10

	property p_set;
		@(posedge CLK_SYS) disable iff (RST)
		below_s |=> flag;
	endproperty
	a_set: assert property (p_set) else $error("flag not set"); // R12

	property p_clr;
		@(posedge CLK_SYS) disable iff (RST)
		(above_s && !below_s) |=> !flag;
	endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared"); // R14

	property p_keep;
		@(posedge CLK_SYS) disable iff (RST)
		(!above_s && !below_s) |=> (flag == $past(flag));
	endproperty
	a_keep: assert property (p_keep) else $error("flag not held"); // R14

	property p_trip;
		@(posedge CLK_SYS) disable iff (RST)
		(state == SUVR_ST_OK && below_s) |=> (CHIP_RESET_REQ && MONITOR_RESET_SRC);
	endproperty
	a_trip: assert property (p_trip) else $error("no reset on trip"); // R11

	property p_irq;
		@(posedge CLK_SYS) disable iff (RST)
		!IRQ_REQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt raised"); // R15

	property p_cfg;
		@(posedge CLK_SYS) disable iff (RST)
		(config_val[3:0] == 4'h0) && MONITOR_ENABLE && TRIP_LEVEL_3V;
	endproperty
	a_cfg: assert property (p_cfg) else $error("config not fixed"); // R7

	property p_vec;
		@(posedge CLK_SYS) disable iff (RST)
		$rose(CHIP_RESET_REQ) |-> FETCH_RESET_VECTOR;
	endproperty
	a_vec: assert property (p_vec) else $error("no vector fetch"); // R18

	property p_release;
		@(posedge CLK_SYS) disable iff (RST)
		(state == SUVR_ST_TRIPPED && above_s && !below_s) |=> !CHIP_RESET_REQ;
	endproperty
	a_release: assert property (p_release) else $error("reset held"); // R8

	property p_restart;
		@(posedge CLK_SYS) disable iff (RST)
		CLOCK_RESTART |-> $rose(CHIP_RESET_REQ);
	endproperty
	a_restart: assert property (p_restart) else $error("stray restart"); // R17

	property p_mode;
		@(posedge CLK_SYS) disable iff (RST)
		CHIP_RESET_REQ |-> (lp_mode == SUVR_MODE_RST);
	endproperty
	a_mode: assert property (p_mode) else $error("mode kept in reset"); // R16

	property p_once;
		@(posedge CLK_SYS) disable iff (RST)
		FETCH_RESET_VECTOR |=> !FETCH_RESET_VECTOR;
	endproperty
	a_once: assert property (p_once) else $error("fetch repeated"); // R18
endmodule : suvr_top
`default_nettype wire

// file: test/suvr_cmp_model.sv
// Purpose: Behavioural supply comparator with hysteresis.
// Assumes: Supply level arrives in millivolts from the bench.
// Notes:   Trip levels are plain defaults, not real figures.
`timescale 1ns/10ps
`default_nettype none
module suvr_cmp_model #(
	parameter int FALL_MV = 2600,
	parameter int RISE_MV = 2700
) (
	input  wire logic [15:0] supply_mv,
	output var  logic        below,
	output var  logic        above
);
	// ==========================================================
	// Decisions; rising level sits above falling level
	always_comb begin
		below = (int'(supply_mv) < FALL_MV);
		above = (int'(supply_mv) > RISE_MV);
	end
endmodule : suvr_cmp_model
`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for the undervoltage reset block.
// Assumes: Zero-wait AHB-Lite slave, comparator model on far side.
// Notes:   Fixed waits follow the three-edge monitor latency.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import suvr_pkg::*;
	// ==========================================================
	// Signals
	logic        clk_sys, rst, hsel, hwrite, hresp, hreadyout, hready;
	logic        chip_rst, pin_out, pin_oe, src, restart_p, fetch_p;
	logic        trip3v, mon_en, irq, below, above;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic [15:0] supply_mv;
	int          num_errors, check_count, cycles, n_restart, n_fetch;
	int          r0, f0;
	logic [31:0] flag_v = 32'h1 << SUVR_BIT_FLAG;
	assign hready = hreadyout;

	suvr_cmp_model cmp (.supply_mv(supply_mv), .below(below), .above(above));
	suvr_top uut (.CLK_SYS(clk_sys), .RST(rst), .BELOW_FALLING(below),
		.ABOVE_RISING(above), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.CHIP_RESET_REQ(chip_rst), .RESET_PIN_OUT(pin_out),
		.RESET_PIN_OE(pin_oe), .MONITOR_RESET_SRC(src),
		.CLOCK_RESTART(restart_p), .FETCH_RESET_VECTOR(fetch_p),
		.TRIP_LEVEL_3V(trip3v), .MONITOR_ENABLE(mon_en), .IRQ_REQ(irq));

	// ==========================================================
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Pulse counters and hang guard
	always @(posedge clk_sys) begin
		if (restart_p === 1'b1) n_restart++;
		if (fetch_p === 1'b1) n_fetch++;
		cycles++;
		if (cycles > 5000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One single-word transfer, entered just after a rising edge
	task automatic ahb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : ahb

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc

	task automatic supply(input logic [15:0] mv, input int n);
		supply_mv <= mv;
		repeat (n) @(posedge clk_sys);
	endtask : supply

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk({29'h0, trip3v, mon_en, irq}, 32'h6);
		chk({30'h0, chip_rst, pin_oe}, 32'h0);
		ahb(1'b1, SUVR_OFS_CONFIG, 32'h0000_000F);
		rdc(SUVR_OFS_CONFIG, 32'h0);
		rdc(SUVR_OFS_STATUS, 32'h0);
		rdc(12'h010, 32'h0);
	endtask : t_reset

	task automatic t_trip();
		r0 = n_restart;
		f0 = n_fetch;
		supply(16'h09C4, 2);
		chk({31'h0, chip_rst}, 32'h0);
		repeat (3) @(posedge clk_sys);
		chk({28'h0, chip_rst, pin_oe, pin_out, src}, 32'hD);
		chk(n_fetch - f0, 32'h1);
		chk(n_restart - r0, 32'h0);
		rdc(SUVR_OFS_CAUSE, 32'h1);
		rdc(SUVR_OFS_STATUS, flag_v);
		ahb(1'b1, SUVR_OFS_STATUS, 32'h0);
		rdc(SUVR_OFS_STATUS, flag_v);
		supply(16'h0A5A, 5);
		chk({31'h0, chip_rst}, 32'h1);
		rdc(SUVR_OFS_STATUS, flag_v);
		supply(16'h0BB8, 5);
		chk({30'h0, chip_rst, pin_oe}, 32'h0);
		rdc(SUVR_OFS_STATUS, 32'h0);
		rdc(SUVR_OFS_CAUSE, 32'h0);
	endtask : t_trip

	task automatic t_modes();
		for (int m = 0; m < 2; m++) begin
			ahb(1'b1, SUVR_OFS_MODE, 32'h1 << m);
			rdc(SUVR_OFS_MODE, 32'h1 << m);
			r0 = n_restart;
			f0 = n_fetch;
			supply(16'h07D0, 5);
			chk(n_restart - r0, 32'h1);
			chk(n_fetch - f0, 32'h1);
			chk({31'h0, chip_rst}, 32'h1);
			rdc(SUVR_OFS_MODE, 32'h0);
			supply(16'h0BB8, 5);
		end
	endtask : t_modes

	task automatic t_rst_clear();
		supply(16'h09C4, 5);
		supply(16'h0A5A, 5);
		rdc(SUVR_OFS_STATUS, flag_v);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk({31'h0, chip_rst}, 32'h0);
		rdc(SUVR_OFS_STATUS, 32'h0);
	endtask : t_rst_clear

	task automatic print_verdict();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 12'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		supply_mv = 16'h0BB8;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_trip();
		t_modes();
		t_rst_clear();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
